/* File: cmd_frame_defs.svh */
`ifndef CMD_FRAME_DEFS_SVH
`define CMD_FRAME_DEFS_SVH

// ------------------------------------------------------------------
// Frame geometry
// ------------------------------------------------------------------
`define CORE_LEN 4'h7
`define SER_LEN 4'h9
`define CAN_REPLY_LEN 4'h6
`define SER_REPLY_LEN 4'h9

// ------------------------------------------------------------------
// Status codes
// ------------------------------------------------------------------
`define ST_OK 8'h64
`define ST_STORED 8'h65
`define ST_BAD_SUM 8'h01
`define ST_BAD_CMD 8'h02
`define ST_BAD_TYPE 8'h03
`define ST_BAD_VALUE 8'h04
`define ST_LOCKED 8'h05
`define ST_NOT_AVAIL 8'h06

`endif

/* File: cmd_frame_pkg.sv */
package cmd_frame_pkg;
    typedef enum logic [3:0] {
        ST_RX = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_TX = 4'b1000
    } phase_e;
endpackage : cmd_frame_pkg

/* File: frame_store.sv */
`timescale 1ns/1ps
// Nine-byte frame store with registered read data
module frame_store #(
    parameter int DEPTH = 9
) (
    input wire logic CLK_I, // Clock
    input wire logic we_i, // Write strobe
    input wire logic [3:0] waddr_i, // Write index
    input wire logic [7:0] wdata_i, // Write byte
    input wire logic [3:0] raddr_i, // Read index
    output logic [7:0] rdata_o // Registered read byte
);
    logic [7:0] mem [DEPTH];
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = mem[raddr_i];
    end

    always_ff @(posedge CLK_I) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= nxt_rdata;
    end
endmodule : frame_store

/* File: cmd_frame_interp.sv */
`timescale 1ns/1ps
`include "cmd_frame_defs.svh"

// Behaviour
// - A command core is 7 bytes: cmd, type, bank, value MSB first.
// - On serial links an address byte leads and a checksum byte trails.
// - The command checksum is the 8-bit sum of the eight bytes before it.
// - On CAN there is no address or checksum; the identifier addresses.
// - Each serial command gets one reply: addrs, status, cmd, value, sum; frames for another module address get none.
// - The reply checksum is the 8-bit sum of all other reply bytes.
// - On CAN the reply has no address or checksum bytes.
// - The device transmits only when answering a received command.
// - The command's actions complete before the reply starts.
// - Status is 100 on success and 101 when stored into program memory.
// - Status is 1 for bad checksum, 2 unknown command, 3 bad type.
// - Status is 4 bad value, 5 locked memory, 6 unavailable command.
module cmd_frame_interp
    import cmd_frame_pkg::*;
(
    input wire logic CLK_I, // Clock, 25 MHz
    input wire logic RSTN_I, // Synchronous reset, active low
    input wire logic CAN_MODE_I, // Link is CAN (strap level)
    input wire logic [7:0] MOD_ADDR_I, // Own module address
    input wire logic [7:0] REPLY_ADDR_I, // Reply address
    input wire logic RX_VALID_I, // Received byte strobe
    input wire logic [7:0] RX_BYTE_I, // Received byte
    input wire logic TX_READY_I, // Transmitter accepts byte
    input wire logic EXEC_DONE_I, // Action finished
    input wire logic [7:0] EXEC_STATUS_I, // Status from executor
    input wire logic [31:0] EXEC_VALUE_I, // Reply value
    output logic CMD_VALID_O, // Command to executor, pulse
    output logic [7:0] CMD_NUM_O, // Command number
    output logic [7:0] CMD_TYPE_O, // Type number
    output logic [7:0] CMD_BANK_O, // Motor or bank number
    output logic [31:0] CMD_VALUE_O, // Value
    output logic TX_VALID_O, // Reply byte valid
    output logic [7:0] TX_BYTE_O, // Reply byte
    output logic TX_LAST_O, // Last reply byte
    output logic BUSY_O // Frame being handled
);
    // --------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------
    logic can_meta_ff, can_ff, rxv_meta_ff, rxv_ff;
    logic [7:0] rxb_meta_ff, rxb_ff;
    logic rxv_dly_ff;
    logic rx_stb;

    always_ff @(posedge CLK_I) begin
        can_meta_ff <= CAN_MODE_I;
        can_ff <= can_meta_ff;
        rxv_meta_ff <= RX_VALID_I;
        rxv_ff <= rxv_meta_ff;
        rxb_meta_ff <= RX_BYTE_I;
        rxb_ff <= rxb_meta_ff;
        rxv_dly_ff <= rxv_ff;
    end

    assign rx_stb = rxv_ff & ~rxv_dly_ff;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic is_err(input logic [7:0] s);
        is_err = (s != `ST_OK) && (s != `ST_STORED);
    endfunction : is_err

    // --------------------------------------------------------------
    // Frame store
    // --------------------------------------------------------------
    phase_e st_ff, nxt_st;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [3:0] ridx;
    logic [7:0] rdata;
    logic store_we;

    // Only bytes taken while receiving land in the store
    assign store_we = rx_stb & (st_ff == ST_RX);

    frame_store #(.DEPTH(9)) u_store (
        .CLK_I(CLK_I),
        .we_i(store_we),
        .waddr_i(cnt_ff),
        .wdata_i(rxb_ff),
        .raddr_i(ridx),
        .rdata_o(rdata)
    );

    // --------------------------------------------------------------
    // Control state
    // --------------------------------------------------------------
    logic [7:0] sum_ff, nxt_sum;
    logic [7:0] stat_ff, nxt_stat;
    logic [31:0] val_ff, nxt_val;
    logic [7:0] cmd_ff, nxt_cmd, typ_ff, nxt_typ, bank_ff, nxt_bank;
    logic cv_ff, nxt_cv;
    logic busy_ff, nxt_busy;
    logic txv_ff, nxt_txv, txl_ff, nxt_txl;
    logic [7:0] txb_ff, nxt_txb;
    logic [3:0] flen, core_base, rlen;
    logic [7:0] txsum;

    assign flen = can_ff ? `CORE_LEN : `SER_LEN;
    assign core_base = can_ff ? 4'h0 : 4'h1;
    assign rlen = can_ff ? `CAN_REPLY_LEN : `SER_REPLY_LEN;
    assign ridx = 4'h0;
    assign txsum = REPLY_ADDR_I + MOD_ADDR_I + stat_ff + cmd_ff
                   + val_ff[31:24] + val_ff[23:16] + val_ff[15:8]
                   + val_ff[7:0];

    always_comb begin
        logic [3:0] pos;
        logic [3:0] k;
        pos = 4'h0;
        k = 4'h0;
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_sum = sum_ff;
        nxt_stat = stat_ff;
        nxt_val = val_ff;
        nxt_cmd = cmd_ff;
        nxt_typ = typ_ff;
        nxt_bank = bank_ff;
        nxt_cv = 1'b0;
        nxt_txv = txv_ff;
        nxt_txl = txl_ff;
        nxt_txb = txb_ff;
        case (st_ff)
            ST_RX: begin
                nxt_txv = 1'b0;
                if (rx_stb) begin
                    pos = cnt_ff - core_base;
                    nxt_cnt = cnt_ff + 4'h1;
                    if (cnt_ff != `CORE_LEN + 4'h1 || can_ff) begin
                        nxt_sum = sum_ff + rxb_ff;
                    end
                    if (pos == 4'h0) nxt_cmd = rxb_ff;
                    if (pos == 4'h1) nxt_typ = rxb_ff;
                    if (pos == 4'h2) nxt_bank = rxb_ff;
                    if (pos >= 4'h3 && pos <= 4'h6) begin
                        nxt_val = {val_ff[23:0], rxb_ff};
                    end
                    if (nxt_cnt == flen) begin
                        nxt_cnt = 4'h0;
                        nxt_sum = 8'h00;
                        if (!can_ff && sum_ff != rxb_ff) begin
                            nxt_stat = `ST_BAD_SUM;
                            nxt_st = ST_WAIT;
                        end else begin
                            nxt_cv = 1'b1;
                            nxt_st = ST_EXEC;
                        end
                        if (!can_ff && sum_ff == rxb_ff
                            && rdata != MOD_ADDR_I) begin
                            nxt_st = ST_RX;
                            nxt_cv = 1'b0;
                        end
                        if (!can_ff && sum_ff != rxb_ff
                            && rdata != MOD_ADDR_I) begin
                            nxt_st = ST_RX;
                        end
                    end
                end
            end
            ST_EXEC: begin
                if (EXEC_DONE_I) begin
                    nxt_stat = EXEC_STATUS_I;
                    nxt_val = is_err(EXEC_STATUS_I) ? val_ff : EXEC_VALUE_I;
                    nxt_st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                nxt_cnt = 4'h0;
                nxt_st = ST_TX;
            end
            ST_TX: begin
                if (!txv_ff || TX_READY_I) begin
                    if (txl_ff && txv_ff) begin
                        nxt_txv = 1'b0;
                        nxt_txl = 1'b0;
                        nxt_cnt = 4'h0;
                        nxt_st = ST_RX;
                    end else begin
                        k = can_ff ? cnt_ff + 4'h2 : cnt_ff;
                        case (k)
                            4'h0: nxt_txb = REPLY_ADDR_I;
                            4'h1: nxt_txb = MOD_ADDR_I;
                            4'h2: nxt_txb = stat_ff;
                            4'h3: nxt_txb = cmd_ff;
                            4'h4: nxt_txb = val_ff[31:24];
                            4'h5: nxt_txb = val_ff[23:16];
                            4'h6: nxt_txb = val_ff[15:8];
                            4'h7: nxt_txb = val_ff[7:0];
                            default: nxt_txb = txsum;
                        endcase
                        nxt_txv = 1'b1;
                        nxt_txl = (cnt_ff + 4'h1 == rlen);
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                end
            end
            default: nxt_st = ST_RX;
        endcase
        nxt_busy = (nxt_st != ST_RX);
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            st_ff <= ST_RX;
            cnt_ff <= 4'h0;
            sum_ff <= 8'h00;
            stat_ff <= 8'h00;
            val_ff <= 32'h0000_0000;
            cmd_ff <= 8'h00;
            typ_ff <= 8'h00;
            bank_ff <= 8'h00;
            cv_ff <= 1'b0;
            busy_ff <= 1'b0;
            txv_ff <= 1'b0;
            txl_ff <= 1'b0;
            txb_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            sum_ff <= nxt_sum;
            stat_ff <= nxt_stat;
            val_ff <= nxt_val;
            cmd_ff <= nxt_cmd;
            typ_ff <= nxt_typ;
            bank_ff <= nxt_bank;
            cv_ff <= nxt_cv;
            busy_ff <= nxt_busy;
            txv_ff <= nxt_txv;
            txl_ff <= nxt_txl;
            txb_ff <= nxt_txb;
        end
    end

    assign CMD_VALID_O = cv_ff;
    assign CMD_NUM_O = cmd_ff;
    assign CMD_TYPE_O = typ_ff;
    assign CMD_BANK_O = bank_ff;
    assign CMD_VALUE_O = val_ff;
    assign TX_VALID_O = txv_ff;
    assign TX_BYTE_O = txb_ff;
    assign TX_LAST_O = txl_ff;
    assign BUSY_O = busy_ff;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    sequence s_byte_held;
        TX_VALID_O && !TX_READY_I;
    endsequence
    sequence s_last_taken;
        TX_VALID_O && TX_READY_I && TX_LAST_O;
    endsequence
    sequence s_reply_start;
        st_ff == ST_WAIT ##1 st_ff == ST_TX;
    endsequence
    sequence s_ser_last;
        store_we && !can_ff && cnt_ff == (`SER_LEN - 4'h1);
    endsequence

    a_tx_only_reply: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        TX_VALID_O |-> st_ff == ST_TX)
        else $error("transmit outside reply");
    a_exec_before_tx: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (st_ff == ST_EXEC && !EXEC_DONE_I) |=> !TX_VALID_O)
        else $error("reply before action done");
    a_cmd_pulse: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        CMD_VALID_O |=> !CMD_VALID_O)
        else $error("command strobe too long");
    a_exec_enter: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        CMD_VALID_O |-> st_ff == ST_EXEC)
        else $error("command without exec");
    a_tx_byte_hold: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        s_byte_held |=> TX_VALID_O && $stable(TX_BYTE_O)
            && $stable(TX_LAST_O))
        else $error("reply byte changed before taken");
    a_reply_close: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        s_last_taken |=> !TX_VALID_O && !BUSY_O)
        else $error("transmit after last reply byte");
    a_reply_first: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        s_reply_start |=> TX_VALID_O
            && TX_BYTE_O == (can_ff ? stat_ff : REPLY_ADDR_I))
        else $error("wrong first reply byte");
    a_bad_sum_reply: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (s_ser_last ##0 (sum_ff != rxb_ff && rdata == MOD_ADDR_I))
            |=> st_ff == ST_WAIT && stat_ff == `ST_BAD_SUM && !CMD_VALID_O)
        else $error("checksum error not reported");
    a_foreign_drop: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (s_ser_last ##0 rdata != MOD_ADDR_I)
            |=> st_ff == ST_RX && !CMD_VALID_O)
        else $error("foreign frame not dropped");
    a_exec_status: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (st_ff == ST_EXEC && EXEC_DONE_I)
            |=> st_ff == ST_WAIT && stat_ff == $past(EXEC_STATUS_I))
        else $error("executor status not kept");
endmodule : cmd_frame_interp

/* File: host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bus master model: sends command bytes, takes reply bytes
// ------------------------------------------------------------
module host_model (
    input wire logic CLK_I, // Clock
    input wire logic tx_valid_i, // Reply byte valid
    input wire logic [7:0] tx_byte_i, // Reply byte
    input wire logic tx_last_i, // Last reply byte
    output logic rx_valid_o, // Command byte strobe
    output logic [7:0] rx_byte_o, // Command byte
    output logic tx_ready_o // Reply byte taken
);
    logic slow = 1'b0;
    initial begin
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
        tx_ready_o = 1'b0;
    end
    // First byte in the top bits; released line shows the inverse
    task automatic send(input logic [71:0] f, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge CLK_I);
            #1;
            rx_byte_o = f[i*8 +: 8];
            rx_valid_o = 1'b1;
            repeat (5) @(posedge CLK_I);
            #1;
            rx_valid_o = 1'b0;
            rx_byte_o = ~rx_byte_o;
            repeat (4) @(posedge CLK_I);
        end
    endtask : send
    // Caller sends nothing new until this returns, on the last byte or after 600 cycles
    task automatic recv(output logic [71:0] r, output int n);
        logic done;
        int t;
        r = '0;
        n = 0;
        done = 1'b0;
        t = 0;
        while (done !== 1'b1 && t < 600) begin
            @(posedge CLK_I);
            t++;
            if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
                r = {r[63:0], tx_byte_i};
                n++;
                done = tx_last_i;
            end
            #1;
            tx_ready_o = (done === 1'b1) ? 1'b0 : (slow ? ~tx_ready_o : 1'b1);
        end
    endtask : recv
endmodule : host_model

/* File: test_motion_cmd_frame_interpreter.sv */
`timescale 1ns/1ps
`include "cmd_frame_defs.svh"
module test_motion_cmd_frame_interpreter;
    localparam logic [7:0] MOD = 8'h2A;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic can = 1'b0;
    logic rxv, txr, cmdv, txv, txl, busy;
    logic [7:0] rxb, txb, cnum, ctyp, cbank;
    logic [31:0] cval;
    logic done = 1'b0;
    logic [7:0] est = 8'h00;
    logic [31:0] eval = '0;
    logic [55:0] core;
    int cmd_seen = 0;
    int bad_count = 0;
    int cmp_count = 0;
    always #20 clk = ~clk;
    cmd_frame_interp u_dut (.CLK_I(clk), .RSTN_I(rstn), .CAN_MODE_I(can),
        .MOD_ADDR_I(MOD), .REPLY_ADDR_I(8'h02), .RX_VALID_I(rxv),
        .RX_BYTE_I(rxb), .TX_READY_I(txr), .EXEC_DONE_I(done),
        .EXEC_STATUS_I(est), .EXEC_VALUE_I(eval), .CMD_VALID_O(cmdv),
        .CMD_NUM_O(cnum), .CMD_TYPE_O(ctyp), .CMD_BANK_O(cbank),
        .CMD_VALUE_O(cval), .TX_VALID_O(txv), .TX_BYTE_O(txb),
        .TX_LAST_O(txl), .BUSY_O(busy));
    host_model u_host (.CLK_I(clk), .tx_valid_i(txv), .tx_byte_i(txb),
        .tx_last_i(txl), .rx_valid_o(rxv), .rx_byte_o(rxb),
        .tx_ready_o(txr));
    // ------------------------------------------------------------
    // Executor: answers each command three cycles later
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (cmdv === 1'b1) begin
            cmd_seen++;
            core = {cnum, ctyp, cbank, cval};
            check(72'(busy), 72'h1, "idle while executing");
            repeat (3) @(posedge clk);
            check(72'(txv), 72'h0, "reply before action done");
            #1 done = 1'b1;
            @(posedge clk);
            #1 done = 1'b0;
        end
    end
    task automatic check(input logic [71:0] s, input logic [71:0] e,
                         input string m);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : check
    function automatic logic [7:0] sum8(input logic [63:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 8; i++) s += b[i*8 +: 8];
        return s;
    endfunction : sum8
    // ------------------------------------------------------------
    // Serial frame with status st, reply value ev, checksum slip bad
    // ------------------------------------------------------------
    task automatic serial(input logic [7:0] adr, input logic [7:0] st,
                          input logic [31:0] ev, input logic bad);
        logic [71:0] f, r, e;
        logic err;
        int n, c0;
        c0 = cmd_seen;
        err = bad || (st !== `ST_OK && st !== `ST_STORED);
        f[71:8] = {adr, st + 8'h10, 8'h04, 8'h01, 32'h12AB_34CD};
        f[7:0] = sum8(f[71:8]) ^ {7'h00, bad};
        est = st;
        eval = ev;
        u_host.send(f, 9);
        u_host.recv(r, n);
        check(72'(busy), 72'h0, "busy after frame");
        if (adr !== MOD) begin
            check(72'(n), 72'h0, "reply to foreign address");
        end else begin
            e[71:8] = {8'h02, MOD, bad ? `ST_BAD_SUM : st, f[63:56],
                       err ? f[39:8] : ev};
            e[7:0] = sum8(e[71:8]);
            check(72'(n), 72'h9, "reply length");
            check(r, e, "reply frame");
            if (!bad) check(72'(core), 72'(f[63:8]), "command core");
        end
        check(72'(cmd_seen - c0), (bad || adr !== MOD) ? 72'h0 : 72'h1,
              "command count");
        if (adr === MOD && n != 9) tally_and_finish();
    endtask : serial
    task automatic can_frame(input logic [7:0] st, input logic [31:0] ev);
        logic [71:0] r;
        logic [31:0] xv;
        int n;
        xv = (st === `ST_OK || st === `ST_STORED) ? ev : 32'h8001_7F02;
        est = st;
        eval = ev;
        u_host.send({16'h0000, 8'h06, 8'h07, 8'h02, 32'h8001_7F02}, 7);
        u_host.recv(r, n);
        check(72'(n), 72'h6, "can reply length");
        check(72'(r[47:0]), 72'({st, 8'h06, xv}), "can reply");
        check(72'(core), 72'h06_0702_8001_7F02, "can core");
        if (n != 6) tally_and_finish();
    endtask : can_frame
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        serial(MOD, `ST_OK, 32'hDEAD_0001, 1'b0);
        u_host.slow = 1'b1;
        serial(MOD, `ST_STORED, 32'h0000_0065, 1'b0);
        u_host.slow = 1'b0;
        serial(MOD, `ST_OK, 32'h0, 1'b1);
        serial(8'h33, `ST_OK, 32'h0, 1'b0);
        for (int s = 2; s <= 6; s++)
            serial(MOD, 8'(s), 32'h5A5A_A5A5, 1'b0);
        can = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        can_frame(`ST_OK, 32'hCAFE_0102);
        can_frame(`ST_BAD_VALUE, 32'h0000_0BAD);
        tally_and_finish();
    end
endmodule : test_motion_cmd_frame_interpreter
